//--- hdl/wsta_pkg.sv
// package of constants for the waveform sequence and timing adjust block
`default_nettype none
package wsta_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_SEQUENCE_MAIN_REPEAT = 8'h19;
  localparam logic [7:0] ADDR_OVERDRIVE_TIME_ADJUST = 8'h1a;
  localparam logic [7:0] ADDR_POSITIVE_SUSTAIN_ADJUST = 8'h1b;
  localparam logic [7:0] ADDR_NEGATIVE_SUSTAIN_ADJUST = 8'h1c;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h3f;
  localparam logic [7:0] RESET_REG = 8'h00;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int REPEAT_LSB = 0;
  localparam int REPEAT_W = 3;
  localparam logic [2:0] REPEAT_FOREVER = 3'h7;
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_ID_W = 8;
  localparam int SLOT_REP_W = 2;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam int DUR_W = 8;
  localparam int ADJ_DUR_W = 9;
  // status: bit 7 busy, bits 5-3 pass, bits 2-0 slot
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_PASS_LSB = 3;
  localparam int STAT_SLOT_LSB = 0;
endpackage
`default_nettype wire

//--- hdl/wsta_duration_adjust.sv
// sample classifier and signed duration adjuster
`default_nettype none
module wsta_duration_adjust (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic sample_valid_in,
  input wire logic signed [7:0] sample_in,
  input wire logic [wsta_pkg::DUR_W-1:0] sample_dur_in,
  input wire logic signed [7:0] wave_max_in,
  input wire logic closed_loop_in,
  input wire logic [7:0] overdrive_time_adjust_in,
  input wire logic [7:0] positive_sustain_adjust_in,
  input wire logic [7:0] negative_sustain_adjust_in,
  output logic adj_valid_out,
  output logic signed [7:0] adj_sample_out,
  output logic [wsta_pkg::ADJ_DUR_W-1:0] adj_dur_out
);
  typedef struct packed {
    logic valid;
    logic signed [7:0] sample;
    logic [wsta_pkg::ADJ_DUR_W-1:0] dur;
  } wsta_adj_state_t;

  wsta_adj_state_t st, next_st;
  logic signed [7:0] offset;
  logic signed [9:0] sum;

  always_comb begin
    // ----------------------------------------
    // classify and pick the offset
    // ----------------------------------------
    if (sample_in == wave_max_in) begin
      offset = closed_loop_in ? 8'sh00 : $signed(overdrive_time_adjust_in);
    end else if (sample_in > 8'sh00) begin
      offset = $signed(positive_sustain_adjust_in);
    end else if (sample_in < 8'sh00) begin
      offset = $signed(negative_sustain_adjust_in);
    end else begin
      offset = 8'sh00;
    end
    // two's complement offset, one step period per unit
    sum = $signed({2'h0, sample_dur_in}) + 10'(offset);
    next_st.valid = sample_valid_in;
    next_st.sample = sample_in;
    // clamp instead of wrapping when shortened past zero
    next_st.dur = sum[9] ? 9'h000 : sum[8:0];
    if (!nrst_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st <= next_st;
  end

  assign adj_valid_out = st.valid;
  assign adj_sample_out = st.sample;
  assign adj_dur_out = st.dur;
endmodule
`default_nettype wire

//--- hdl/wsta_sequencer.sv
// sequence loop control, timing adjust registers and duration adjuster
`default_nettype none
module wsta_sequencer (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic launch_in,
  input wire logic trigger_stop_in,
  input wire logic closed_loop_in,
  input wire logic [wsta_pkg::SLOT_COUNT*wsta_pkg::SLOT_ID_W-1:0] slot_ids_in,
  input wire logic [wsta_pkg::SLOT_COUNT*wsta_pkg::SLOT_REP_W-1:0] slot_repeat_count_in,
  input wire logic effect_done_in,
  output logic effect_start_out,
  output logic [wsta_pkg::SLOT_ID_W-1:0] effect_id_out,
  output logic busy_out,
  input wire logic sample_valid_in,
  input wire logic signed [7:0] sample_in,
  input wire logic [wsta_pkg::DUR_W-1:0] sample_dur_in,
  input wire logic signed [7:0] wave_max_in,
  output logic adj_valid_out,
  output logic signed [7:0] adj_sample_out,
  output logic [wsta_pkg::ADJ_DUR_W-1:0] adj_dur_out
);
  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  typedef enum {S_IDLE, S_ISSUE, S_WAIT} wsta_phase_t;

  typedef struct packed {
    logic [7:0] sequence_main_repeat;
    logic [7:0] overdrive_time_adjust;
    logic [7:0] positive_sustain_adjust;
    logic [7:0] negative_sustain_adjust;
    logic [7:0] rdata;
    logic [2:0] trig_sync;
    logic trig_level;
    logic launch_q;
    wsta_phase_t phase;
    logic [2:0] slot;
    logic [1:0] rep;
    logic [2:0] pass;
    logic start;
    logic [7:0] id;
  } wsta_seq_state_t;

  wsta_seq_state_t st, next_st;
  logic stop_evt;
  logic [2:0] sequence_repeat_count;
  logic [wsta_pkg::SLOT_COUNT-1:0] slot_live;
  logic [wsta_pkg::SLOT_REP_W-1:0] slot_rep_of [wsta_pkg::SLOT_COUNT];

  // ----------------------------------------
  // slot lookups
  // ----------------------------------------
  function automatic logic [7:0] slot_id(input logic [63:0] ids, input logic [2:0] idx);
    slot_id = ids[idx*8 +: 8];
  endfunction

  // one decoder per slot, so the pass end test is a single bit select
  for (genvar g = 0; g < wsta_pkg::SLOT_COUNT; g++) begin : g_slot
    assign slot_live[g] = (slot_ids_in[g*wsta_pkg::SLOT_ID_W +: wsta_pkg::SLOT_ID_W] != 8'h00);
    assign slot_rep_of[g] = slot_repeat_count_in[g*wsta_pkg::SLOT_REP_W +: wsta_pkg::SLOT_REP_W];
  end

  assign sequence_repeat_count = st.sequence_main_repeat[wsta_pkg::REPEAT_LSB +: wsta_pkg::REPEAT_W];

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // ----------------------------------------
    // trigger pin filter
    // ----------------------------------------
    // stage one feeds only stage two; a change counts when two and three agree
    next_st.trig_sync = {st.trig_sync[1:0], trigger_stop_in};
    if (st.trig_sync[1] == st.trig_sync[2]) begin
      next_st.trig_level = st.trig_sync[2];
    end
    stop_evt = (next_st.trig_level && !st.trig_level) || !launch_in;
    next_st.launch_q = launch_in;
    // ----------------------------------------
    // register writes and reads
    // ----------------------------------------
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        wsta_pkg::ADDR_SEQUENCE_MAIN_REPEAT: next_st.sequence_main_repeat = reg_wdata_in;
        wsta_pkg::ADDR_OVERDRIVE_TIME_ADJUST: next_st.overdrive_time_adjust = reg_wdata_in;
        wsta_pkg::ADDR_POSITIVE_SUSTAIN_ADJUST: next_st.positive_sustain_adjust = reg_wdata_in;
        wsta_pkg::ADDR_NEGATIVE_SUSTAIN_ADJUST: next_st.negative_sustain_adjust = reg_wdata_in;
        default: ;
      endcase
    end
    unique case (reg_addr_in)
      wsta_pkg::ADDR_SEQUENCE_MAIN_REPEAT: next_st.rdata = st.sequence_main_repeat;
      wsta_pkg::ADDR_OVERDRIVE_TIME_ADJUST: next_st.rdata = st.overdrive_time_adjust;
      wsta_pkg::ADDR_POSITIVE_SUSTAIN_ADJUST: next_st.rdata = st.positive_sustain_adjust;
      wsta_pkg::ADDR_NEGATIVE_SUSTAIN_ADJUST: next_st.rdata = st.negative_sustain_adjust;
      wsta_pkg::ADDR_SEQ_STATUS: begin
        next_st.rdata = 8'h00;
        next_st.rdata[wsta_pkg::STAT_BUSY_BIT] = (st.phase != S_IDLE);
        next_st.rdata[wsta_pkg::STAT_PASS_LSB +: 3] = st.pass;
        next_st.rdata[wsta_pkg::STAT_SLOT_LSB +: 3] = st.slot;
      end
      default: next_st.rdata = 8'h00;
    endcase
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    unique case (st.phase)
      S_IDLE: begin
        // launch edge only, so a finished sequence does not restart while the bit stays set
        if (launch_in && !st.launch_q) begin
          next_st.slot = 3'h0;
          next_st.rep = 2'h0;
          next_st.pass = 3'h0;
          if (slot_live[0]) begin
            next_st.phase = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        next_st.start = 1'b1;
        next_st.id = slot_id(slot_ids_in, st.slot);
        next_st.phase = S_WAIT;
      end
      S_WAIT: begin
        if (effect_done_in) begin
          if (st.rep < slot_rep_of[st.slot]) begin
            next_st.rep = st.rep + 2'h1;
            next_st.phase = S_ISSUE;
          end else if (st.slot != wsta_pkg::LAST_SLOT &&
                       slot_live[3'(st.slot + 3'h1)]) begin
            next_st.rep = 2'h0;
            next_st.slot = st.slot + 3'h1;
            next_st.phase = S_ISSUE;
          end else if (sequence_repeat_count == wsta_pkg::REPEAT_FOREVER) begin
            // pass is left alone here so the status count cannot wrap
            next_st.rep = 2'h0;
            next_st.slot = 3'h0;
            next_st.phase = S_ISSUE;
          end else if (st.pass < sequence_repeat_count) begin
            next_st.rep = 2'h0;
            next_st.slot = 3'h0;
            next_st.pass = st.pass + 3'h1;
            next_st.phase = S_ISSUE;
          end else begin
            next_st.phase = S_IDLE;
          end
        end
      end
    endcase
    // a stop also drops a start that is about to issue
    if (stop_evt && st.phase != S_IDLE) begin
      next_st.phase = S_IDLE;
      next_st.start = 1'b0;
    end
    if (!nrst_in) begin
      next_st = '0;
      next_st.phase = S_IDLE;
      next_st.sequence_main_repeat = wsta_pkg::RESET_REG;
      next_st.overdrive_time_adjust = wsta_pkg::RESET_REG;
      next_st.positive_sustain_adjust = wsta_pkg::RESET_REG;
      next_st.negative_sustain_adjust = wsta_pkg::RESET_REG;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_out = st.rdata;
  assign effect_start_out = st.start;
  assign effect_id_out = st.id;
  assign busy_out = (st.phase != S_IDLE);

  // ----------------------------------------
  // portion duration adjustment
  // ----------------------------------------
  wsta_duration_adjust u_adjust (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_in),
    .sample_dur_in(sample_dur_in),
    .wave_max_in(wave_max_in),
    .closed_loop_in(closed_loop_in),
    .overdrive_time_adjust_in(st.overdrive_time_adjust),
    .positive_sustain_adjust_in(st.positive_sustain_adjust),
    .negative_sustain_adjust_in(st.negative_sustain_adjust),
    .adj_valid_out(adj_valid_out),
    .adj_sample_out(adj_sample_out),
    .adj_dur_out(adj_dur_out)
  );
endmodule
`default_nettype wire

//--- bench/wsta_monitor.sv
// port checker for the sequencer and adjuster
`default_nettype none
module wsta_monitor (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic launch_in,
  input wire logic [63:0] slot_ids_in,
  input wire logic effect_start_out,
  input wire logic busy_out,
  input wire logic sample_valid_in,
  input wire logic signed [7:0] sample_in,
  input wire logic [7:0] sample_dur_in,
  input wire logic signed [7:0] wave_max_in,
  input wire logic closed_loop_in,
  input wire logic adj_valid_out,
  input wire logic [8:0] adj_dur_out
);
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // up keeps $past from looking into reset
  logic up;
  always_ff @(posedge sys_clk_in) up <= nrst_in;
  a_adj_one_lag: assert property (up |-> adj_valid_out == $past(sample_valid_in))
    else $error("adjust valid lag wrong");
  a_od_closed_keep: assert property (up && $past(sample_valid_in && closed_loop_in && sample_in == wave_max_in)
    |-> adj_dur_out == {1'b0, $past(sample_dur_in)}) else $error("closed loop overdrive adjusted");
  a_zero_keep: assert property (up && $past(sample_valid_in && sample_in == 0 && wave_max_in != 0)
    |-> adj_dur_out == {1'b0, $past(sample_dur_in)}) else $error("zero sample adjusted");
  a_start_one_cycle: assert property (effect_start_out |=> !effect_start_out)
    else $error("start pulse too long");
  a_start_when_busy: assert property (effect_start_out |-> busy_out)
    else $error("start while idle");
  a_launch_starts: assert property (up && $rose(launch_in) && !busy_out && slot_ids_in[7:0] != 0
    |-> ##2 effect_start_out) else $error("launch gave no start");
  a_launch_low_stop: assert property (!launch_in && busy_out |=> !busy_out)
    else $error("launch clear did not stop");
  a_reg_echo: assert property (reg_wr_in && reg_addr_in inside {[8'h19:8'h1c]} ##1 $stable(reg_addr_in)
    ##1 $stable(reg_addr_in) |-> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("register lost write");
  a_unmapped_zero: assert property (up && $stable(reg_addr_in) && !(reg_addr_in inside {[8'h19:8'h1c], 8'h3f})
    |-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  c_start: cover property (effect_start_out);
  c_closed: cover property (adj_valid_out && closed_loop_in);
  c_end: cover property (busy_out ##1 !busy_out);
endmodule
bind wsta_sequencer wsta_monitor u_mon (.sys_clk_in, .nrst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
  .reg_rdata_out, .launch_in, .slot_ids_in, .effect_start_out, .busy_out, .sample_valid_in, .sample_in,
  .sample_dur_in, .wave_max_in, .closed_loop_in, .adj_valid_out, .adj_dur_out);
`default_nettype wire

//--- bench/wsta_sequencer_tb.sv
// self-checking bench for the sequence and adjust block
`default_nettype none
module wsta_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, wr = 0, go = 0, done = 0, closed = 0, sv = 0, trig = 0, start, busy, av;
  logic [7:0] addr = 0, wd = 0, rd, id, smp = 0, dur = 0, mx = 0, adjr [3], asmp;
  logic [63:0] ids = 0;
  logic [15:0] reps = 0;
  logic [8:0] adur, dq [$];
  logic [7:0] iq [$], sq [$];
  logic [31:0] rs = 32'hd430;
  int bad_count = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  wsta_sequencer dut (.sys_clk_in(clk), .nrst_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd),
    .reg_rdata_out(rd), .launch_in(go), .trigger_stop_in(trig), .closed_loop_in(closed), .slot_ids_in(ids),
    .slot_repeat_count_in(reps), .effect_done_in(done), .effect_start_out(start), .effect_id_out(id),
    .busy_out(busy), .sample_valid_in(sv), .sample_in(smp), .sample_dur_in(dur), .wave_max_in(mx),
    .adj_valid_out(av), .adj_sample_out(asmp), .adj_dur_out(adur));
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(string nm, logic [8:0] e, logic [8:0] g);
    n_compared++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1;
    tick();
    wr = 0;
  endtask
  // two edges so the registered read path has settled
  task automatic rreg(logic [7:0] a, logic [7:0] e);
    addr = a;
    tick(2);
    check("rdata", {1'b0, e}, {1'b0, rd});
  endtask
  function automatic logic [8:0] exp_dur(logic signed [7:0] s, logic signed [7:0] m, logic [7:0] d);
    int a = 0;
    if (s == m) a = closed ? 0 : $signed(adjr[0]);
    else if (s > 0) a = $signed(adjr[1]);
    else if (s < 0) a = $signed(adjr[2]);
    a = a + d;
    return a < 0 ? 9'h0 : 9'(a);
  endfunction
  // results are popped as they appear, so order is checked too
  always @(negedge clk) begin
    if (av !== 1'b0) begin
      check("adj_dur", dq.size() ? dq.pop_front() : 9'h1ff, adur);
      check("adj_sample", sq.size() ? {1'b0, sq.pop_front()} : 9'h1ff, {1'b0, asmp});
    end
    if (start !== 1'b0) check("effect_id", iq.size() ? {1'b0, iq.pop_front()} : 9'h1ff, {1'b0, id});
  end
  task automatic run_seq(logic [7:0] main, int n);
    int t;
    wreg(8'h19, main);
    rreg(8'h19, main);
    for (int p = 0; p <= (main[2:0] == 7 ? 99 : main[2:0]); p++)
      for (int s = 0; s < 8 && ids[8*s+:8] != 0; s++)
        for (int r = 0; r <= reps[2*s+:2]; r++)
          if (iq.size() < n) iq.push_back(ids[8*s+:8]);
    n = iq.size();
    go = 1;
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (!start && t < 20) begin
        tick();
        t++;
      end
      tick(2);
      // endless mode is ended mid-effect by the trigger pin or by clearing launch
      if (i == n - 1 && main[2:0] == 7 && main[3]) trig = 1;
      else if (i == n - 1 && main[2:0] == 7) go = 0;
      else done = 1;
      tick();
      done = 0;
    end
    tick(4);
    check("busy", 9'h0, {8'h0, busy});
    check("unplayed", 9'h0, 9'(iq.size()));
    iq.delete();
    go = 0;
    trig = 0;
    tick(2);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
  initial begin
    tick(12);
    rst_n = 1;
    for (int j = 0; j < 4; j++) rreg(8'(8'h19 + j), 8'h00);
    wreg(8'h20, 8'h5a);
    rreg(8'h20, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 60; k++) begin
      if (k % 12 == 0) begin
        sv = 0;
        closed = (k / 12) % 2 == 1;
        for (int j = 0; j < 3; j++) begin
          adjr[j] = 8'(rnd());
          wreg(8'(8'h1a + j), adjr[j]);
          rreg(8'(8'h1a + j), adjr[j]);
        end
      end
      mx = 8'(rnd());
      smp = (k % 7 == 3) ? 8'h00 : (rs[16] ? mx : rs[23:16]);
      dur = rs[24] ? {5'h0, rs[27:25]} : rs[31:24];
      sv = 1;
      dq.push_back(exp_dur(smp, mx, dur));
      sq.push_back(smp);
      tick();
    end
    sv = 0;
    tick(2);
    $display("test adjust done");
    rst_n = 0;
    tick(2);
    rst_n = 1;
    for (int j = 0; j < 3; j++) rreg(8'(8'h1a + j), 8'h00);
    ids = 64'h2211;
    reps = 16'h0001;
    run_seq(8'h09, 1000);
    run_seq(8'hff, 9);
    run_seq(8'h07, 4);
    ids = {rnd(), rnd()} | 64'h0101010101010101;
    reps = 16'(rnd());
    run_seq(8'h00, 1000);
    ids = 0;
    run_seq(8'h02, 1000);
    $display("test sequence done");
    summarize();
  end
endmodule
`default_nettype wire
